// ===== clk_tree_map.svh
// Register offsets, field positions, reset values and timing counts of the clock tree
`ifndef CLK_TREE_MAP_SVH
`define CLK_TREE_MAP_SVH

// Byte address layout: bit 7 set is unmapped, bit 6 picks the PLL bank
`define BANK_SEL_BIT 6
`define UNMAPPED_BIT 7

// Offsets inside one bank
`define OFS_CTRL 6'h00
`define OFS_MULT 6'h04
`define OFS_POST 6'h08
`define OFS_STATUS 6'h0C
`define OFS_DIV_FIRST 6'h10
`define OFS_DIV_LAST 6'h28

// Field positions
`define CTRL_ACTIVE_BIT 0
`define CTRL_BYPSEL_BIT 1
`define DIV_EN_BIT 15
`define STATUS_LOCK_BIT 31

// Reset values
`define RST_CTRL 2'h0
`define RST_MULT 5'h17
`define RST_POST 5'h01
`define RST_DIV_EN 7'h7F
// Domain 7 down to domain 1; cpu clock is domain 6 at divide-by-1
`define RST_DIV_A {5'h05, 5'h00, 5'h00, 5'h03, 5'h02, 5'h01, 5'h00}
`define RST_DIV_B {5'h00, 5'h00, 5'h00, 5'h00, 5'h02, 5'h01, 5'h00}

// Reference edges seen before the multiplied clock is trusted
`define LOCK_REF_EDGES 2'h2

`endif

// ===== clk_tree_pkg.sv
// Types shared by the clock tree modules
package clk_tree_pkg;
   typedef logic [4:0] ratio_t;
   typedef enum logic [1:0] {
      LOCK_IDLE = 2'b00,
      LOCK_MEASURE = 2'b01,
      LOCK_HOLD = 2'b11
   } lock_state_t;
endpackage

// ===== pll_clock_core.sv
// One PLL: bypass/active source, multiplier, post divider and domain divider bank
`timescale 1ns/10ps
`include "clk_tree_map.svh"
module pll_clock_core #(
   parameter int NUM_DOMAINS = 7,
   parameter int PERIOD_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ref_tick,
   input wire logic bypass_ref_tick,
   input wire logic bypass_source_select,
   input wire logic active_mode,
   input wire clk_tree_pkg::ratio_t pll_multiplier_setting,
   input wire clk_tree_pkg::ratio_t post_ratio,
   input wire logic [NUM_DOMAINS*5-1:0] div_ratios,
   input wire logic [NUM_DOMAINS-1:0] div_enables,
   output logic [NUM_DOMAINS-1:0] domain_ticks,
   output logic [PERIOD_W-1:0] ref_period,
   output logic locked
);
   import clk_tree_pkg::*;

   generate
      if (PERIOD_W < 8 || NUM_DOMAINS < 1) begin : g_bad_params
         $error("pll_clock_core: PERIOD_W must be >= 8 and NUM_DOMAINS >= 1");
      end
   endgenerate

   lock_state_t lock_reg, lock_next;
   logic [PERIOD_W-1:0] meas_reg;
   logic [PERIOD_W:0] acc_reg, acc_next;
   logic [1:0] edge_reg;
   ratio_t post_cnt_reg;
   logic post_tick_reg;

   // Bypass reference: oscillator, or for the first PLL another PLL's domain 3
   wire bypass_src = bypass_source_select ? bypass_ref_tick : ref_tick;
   wire meas_full = &meas_reg;
   wire [PERIOD_W:0] mult_inc = {{(PERIOD_W-5){1'b0}}, {1'b0, pll_multiplier_setting} + 6'h01};
   wire [PERIOD_W:0] acc_sum = acc_reg + mult_inc;
   wire [PERIOD_W:0] period_ext = {1'b0, ref_period};
   wire mult_tick = (lock_reg == LOCK_HOLD) && (acc_sum >= period_ext);
   wire [PERIOD_W:0] acc_over = acc_sum - period_ext;
   // Output held quiet while the multiplier acquires, so no runt pulses escape
   wire src_tick = active_mode ? mult_tick : bypass_src;
   wire post_wrap = src_tick && (post_cnt_reg == post_ratio);

   assign locked = (lock_reg == LOCK_HOLD);

   always_comb begin
      lock_next = lock_reg;
      unique case (lock_reg)
         LOCK_IDLE: if (active_mode) lock_next = LOCK_MEASURE;
         LOCK_MEASURE: if (edge_reg == `LOCK_REF_EDGES) lock_next = LOCK_HOLD;
         LOCK_HOLD: if (!active_mode) lock_next = LOCK_IDLE;
      endcase
      if (!active_mode) lock_next = LOCK_IDLE;
   end

   // Multiplier as a rate accumulator; saturates at one pulse per system clock
   always_comb begin
      acc_next = acc_reg;
      if (lock_reg != LOCK_HOLD) acc_next = '0;
      else if (mult_tick) acc_next = (acc_over >= period_ext) ? '0 : acc_over;
      else acc_next = acc_sum;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lock_reg <= LOCK_IDLE;
         meas_reg <= '0;
         ref_period <= '1;
         edge_reg <= 2'h0;
         acc_reg <= '0;
      end else begin
         lock_reg <= lock_next;
         acc_reg <= acc_next;
         meas_reg <= ref_tick ? '0 : (meas_full ? meas_reg : meas_reg + 1'b1);
         if (ref_tick) ref_period <= meas_full ? meas_reg : meas_reg + 1'b1;
         if (lock_reg != LOCK_MEASURE) edge_reg <= 2'h0;
         else if (ref_tick && edge_reg != `LOCK_REF_EDGES) edge_reg <= edge_reg + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         post_cnt_reg <= '0;
         post_tick_reg <= 1'b0;
      end else begin
         post_tick_reg <= post_wrap;
         if (post_wrap) post_cnt_reg <= '0;
         else if (src_tick) post_cnt_reg <= post_cnt_reg + 5'h01;
      end
   end

   // One private divider per domain, each with its own ratio
   genvar d;
   generate
      for (d = 0; d < NUM_DOMAINS; d++) begin : g_dom
         ratio_t cnt_reg;
         wire ratio_t ratio = div_ratios[d*5 +: 5];
         wire wrap = post_tick_reg && (cnt_reg == ratio);
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               cnt_reg <= '0;
               domain_ticks[d] <= 1'b0;
            end else begin
               domain_ticks[d] <= wrap && div_enables[d];
               if (wrap || !div_enables[d]) cnt_reg <= '0;
               else if (post_tick_reg) cnt_reg <= cnt_reg + 5'h01;
            end
         end
      end
   endgenerate
endmodule

// ===== pll_system_clock_tree.sv
// Two-PLL system clock tree with an Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "clk_tree_map.svh"
module pll_system_clock_tree #(
   parameter int NUM_DOMAINS = 7,
   parameter int PERIOD_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ref_osc_input,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [NUM_DOMAINS-1:0] pll_a_clock_ticks,
   output logic [NUM_DOMAINS-1:0] pll_b_clock_ticks,
   output logic pll_a_locked,
   output logic pll_b_locked
);
   import clk_tree_pkg::*;

   generate
      if (NUM_DOMAINS != 7 || PERIOD_W > 16 || PERIOD_W < 8) begin : g_bad_params
         $error("pll_system_clock_tree: needs 7 domains and 8..16 bit period");
      end
   endgenerate

   localparam int CPU_IDX = 5;
   localparam int DOM2_IDX = 1;
   localparam int DOM3_IDX = 2;
   localparam int DOM4_IDX = 3;

   function automatic logic ofs_is_div(input logic [5:0] ofs);
      return (ofs >= `OFS_DIV_FIRST) && (ofs <= `OFS_DIV_LAST) && (ofs[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] div_index(input logic [5:0] ofs);
      logic [5:0] rel;
      rel = ofs - `OFS_DIV_FIRST;
      return rel[4:2];
   endfunction

   // Register state, one entry per PLL bank
   logic [1:0] ctrl_reg [0:1];
   ratio_t mult_reg [0:1];
   ratio_t post_reg [0:1];
   logic [NUM_DOMAINS*5-1:0] div_ratio_reg [0:1];
   logic [NUM_DOMAINS-1:0] div_en_reg [0:1];

   logic waitrequest_reg;
   logic [31:0] readdata_reg;

   logic [NUM_DOMAINS-1:0] ticks_a, ticks_b;
   logic [PERIOD_W-1:0] period_a, period_b;
   logic locked_a, locked_b;
   logic [1:0] cpu_cnt_reg;

   // Bus decode
   wire bank = avs_address[`BANK_SEL_BIT];
   wire [5:0] ofs = avs_address[5:0];
   wire mapped = !avs_address[`UNMAPPED_BIT];
   wire hit_ctrl = mapped && (ofs == `OFS_CTRL);
   wire hit_mult = mapped && (ofs == `OFS_MULT);
   wire hit_post = mapped && (ofs == `OFS_POST);
   wire hit_status = mapped && (ofs == `OFS_STATUS);
   wire hit_div = mapped && ofs_is_div(ofs);
   wire [2:0] idx = div_index(ofs);
   // A request completes in the cycle waitrequest is low
   wire wr_fire = avs_write && !waitrequest_reg;
   wire rd_start = (avs_read || avs_write) && waitrequest_reg;

   // Read mux
   wire [PERIOD_W-1:0] rd_period = bank ? period_b : period_a;
   wire rd_locked = bank ? locked_b : locked_a;
   wire [15:0] rd_period_ext = 16'(rd_period);
   wire [31:0] rd_ctrl = {30'h0, ctrl_reg[bank]};
   wire [31:0] rd_mult = {27'h0, mult_reg[bank]};
   wire [31:0] rd_post = {27'h0, post_reg[bank]};
   wire [31:0] rd_status = {rd_locked, 15'h0, rd_period_ext};
   wire [4:0] rd_ratio = div_ratio_reg[bank][int'(idx)*5 +: 5];
   wire [31:0] rd_div = {16'h0, div_en_reg[bank][idx], 10'h0, rd_ratio};
   wire [31:0] rd_value = hit_ctrl ? rd_ctrl :
                          hit_mult ? rd_mult :
                          hit_post ? rd_post :
                          hit_status ? rd_status :
                          hit_div ? rd_div : 32'h0;

   // One wait cycle per access, then readdata and completion together
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         waitrequest_reg <= 1'b1;
         readdata_reg <= 32'h0;
      end else begin
         waitrequest_reg <= !rd_start;
         if (rd_start && avs_read) readdata_reg <= rd_value;
      end
   end

   assign avs_waitrequest = waitrequest_reg;
   assign avs_readdata = readdata_reg;

   // Register writes, per bank
   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         localparam logic [NUM_DOMAINS*5-1:0] DIV_RST = (b == 0) ? `RST_DIV_A : `RST_DIV_B;
         // Only the first PLL has a bypass source select
         localparam logic [1:0] CTRL_MASK = (b == 0) ? 2'h3 : 2'h1;
         wire sel = wr_fire && (bank == b);
         // Cpu-tied domains of the first PLL keep their ratio fixed
         wire div_locked = (b == 0) && (idx == 3'(DOM2_IDX) || idx == 3'(DOM4_IDX));
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               ctrl_reg[b] <= `RST_CTRL;
               mult_reg[b] <= `RST_MULT;
               post_reg[b] <= `RST_POST;
               div_ratio_reg[b] <= DIV_RST;
            end else if (sel && avs_byteenable[0]) begin
               if (hit_ctrl) ctrl_reg[b] <= avs_writedata[1:0] & CTRL_MASK;
               if (hit_mult) mult_reg[b] <= avs_writedata[4:0];
               if (hit_post) post_reg[b] <= avs_writedata[4:0];
               if (hit_div && !div_locked) div_ratio_reg[b][int'(idx)*5 +: 5] <= avs_writedata[4:0];
            end
         end
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               div_en_reg[b] <= `RST_DIV_EN;
            end else if (sel && hit_div && avs_byteenable[1]) begin
               div_en_reg[b][idx] <= avs_writedata[`DIV_EN_BIT];
            end
         end
      end
   endgenerate

   // Second PLL is built first: its domain 3 may feed the first PLL's bypass
   pll_clock_core #(
      .NUM_DOMAINS(NUM_DOMAINS),
      .PERIOD_W(PERIOD_W)
   ) u_pll_b (
      .clk(clk),
      .reset(reset),
      .ref_tick(ref_osc_input),
      .bypass_ref_tick(1'b0),
      .bypass_source_select(1'b0),
      .active_mode(ctrl_reg[1][`CTRL_ACTIVE_BIT]),
      .pll_multiplier_setting(mult_reg[1]),
      .post_ratio(post_reg[1]),
      .div_ratios(div_ratio_reg[1]),
      .div_enables(div_en_reg[1]),
      .domain_ticks(ticks_b),
      .ref_period(period_b),
      .locked(locked_b)
   );

   pll_clock_core #(
      .NUM_DOMAINS(NUM_DOMAINS),
      .PERIOD_W(PERIOD_W)
   ) u_pll_a (
      .clk(clk),
      .reset(reset),
      .ref_tick(ref_osc_input),
      .bypass_ref_tick(ticks_b[DOM3_IDX]),
      .bypass_source_select(ctrl_reg[0][`CTRL_BYPSEL_BIT]),
      .active_mode(ctrl_reg[0][`CTRL_ACTIVE_BIT]),
      .pll_multiplier_setting(mult_reg[0]),
      .post_ratio(post_reg[0]),
      .div_ratios(div_ratio_reg[0]),
      .div_enables(div_en_reg[0]),
      .domain_ticks(ticks_a),
      .ref_period(period_a),
      .locked(locked_a)
   );

   // Domains 2 and 4 count cpu pulses so they can never drift off 1:2 and 1:4
   wire cpu_tick = ticks_a[CPU_IDX];
   wire dom2_tick = cpu_tick && cpu_cnt_reg[0] && div_en_reg[0][DOM2_IDX];
   wire dom4_tick = cpu_tick && (cpu_cnt_reg == 2'h3) && div_en_reg[0][DOM4_IDX];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpu_cnt_reg <= 2'h0;
      end else if (cpu_tick) begin
         cpu_cnt_reg <= cpu_cnt_reg + 2'h1;
      end
   end

   // Domains 1, 3, 5, 6 and 7, and every domain of the second PLL, come straight from their own dividers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pll_a_clock_ticks <= '0;
         pll_b_clock_ticks <= '0;
         pll_a_locked <= 1'b0;
         pll_b_locked <= 1'b0;
      end else begin
         pll_a_clock_ticks <= ticks_a;
         pll_a_clock_ticks[DOM2_IDX] <= dom2_tick;
         pll_a_clock_ticks[DOM4_IDX] <= dom4_tick;
         pll_b_clock_ticks <= ticks_b;
         pll_a_locked <= locked_a;
         pll_b_locked <= locked_b;
      end
   end
endmodule

// ===== osc_ref_model.sv
// Reference oscillator model: one-cycle pulse every period cycles
`timescale 1ns/10ps
module osc_ref_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] period,
   output logic pulse
);
   logic [7:0] count_reg;
   logic [7:0] count_next;
   // Free running, as a crystal never pauses
   assign count_next = (count_reg >= period - 8'h01) ? 8'h00 : count_reg + 8'h01;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_reg <= 8'h00;
         pulse <= 1'b0;
      end else begin
         count_reg <= count_next;
         pulse <= (count_next == 8'h00);
      end
   end
endmodule

// ===== pll_system_clock_tree_asserts.sv
// Port-level assertions for the two-PLL clock tree
`timescale 1ns/10ps
module clock_tree_checker #(
   parameter int NUM_DOMAINS = 7
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ref_osc_input,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NUM_DOMAINS-1:0] pll_a_clock_ticks,
   input wire logic [NUM_DOMAINS-1:0] pll_b_clock_ticks,
   input wire logic pll_a_locked,
   input wire logic pll_b_locked
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [2:0] cpu2_reg, cpu2_next, cpu4_reg, cpu4_next;
   logic [3:0] age_reg, age_next;
   logic rd_done;
   // Cpu pulses since the last domain 2 or domain 4 pulse
   assign cpu2_next = pll_a_clock_ticks[1] ? {2'h0, pll_a_clock_ticks[5]} :
                      cpu2_reg + {2'h0, pll_a_clock_ticks[5]};
   assign cpu4_next = pll_a_clock_ticks[3] ? {2'h0, pll_a_clock_ticks[5]} :
                      cpu4_reg + {2'h0, pll_a_clock_ticks[5]};
   assign age_next = ref_osc_input ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
   assign rd_done = avs_read && !avs_waitrequest;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpu2_reg <= 3'h0;
         cpu4_reg <= 3'h0;
         age_reg <= 4'h0;
      end else begin
         cpu2_reg <= cpu2_next;
         cpu4_reg <= cpu4_next;
         age_reg <= age_next;
      end
   end
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_WAIT_ONE: assert property (s_req |=> s_ans)
      else $error("waitrequest not low for exactly one cycle");
   AST_IDLE_WAIT: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest dropped with no request");
   AST_UNMAPPED_ZERO: assert property (rd_done && avs_address[7] |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_CTRL_A_RSV: assert property (rd_done && avs_address == 8'h00 |-> avs_readdata[31:2] == 30'h0)
      else $error("reserved control bits set");
   AST_CTRL_B_NOSEL: assert property (rd_done && avs_address == 8'h40 |-> avs_readdata[31:1] == 31'h0)
      else $error("second bank shows bypass select");
   AST_B_BYPASS_SRC: assert property ((|pll_b_clock_ticks) && !pll_b_locked && !$past(pll_b_locked, 5)
      |-> $past(ref_osc_input, 3)) else $error("bypass tick without reference pulse");
   AST_A_BYPASS_SRC: assert property (((pll_a_clock_ticks & 7'h75) != 7'h00) && !pll_a_locked
      && !$past(pll_a_locked, 5) |-> $past(ref_osc_input, 3) || $past(pll_b_clock_ticks[2], 2)
      || $past(pll_b_clock_ticks[2], 3)) else $error("bypass tick without source pulse");
   AST_DOM2_RATIO: assert property (cpu2_reg <= 3'h2)
      else $error("domain 2 missed its cpu ratio");
   AST_DOM4_RATIO: assert property (cpu4_reg <= 3'h4)
      else $error("domain 4 missed its cpu ratio");
   AST_LOCK_AFTER_REF: assert property ($rose(pll_b_locked) |-> age_reg <= 4'h4)
      else $error("lock not tied to a reference pulse");
endmodule
bind pll_system_clock_tree clock_tree_checker #(.NUM_DOMAINS(NUM_DOMAINS)) chk (
   .clk(clk), .reset(reset), .ref_osc_input(ref_osc_input), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pll_a_clock_ticks(pll_a_clock_ticks),
   .pll_b_clock_ticks(pll_b_clock_ticks), .pll_a_locked(pll_a_locked),
   .pll_b_locked(pll_b_locked));

// ===== test_pll_system_clock_tree.sv
// Self-checking bench for the two-PLL clock tree
`timescale 1ns/10ps
module test_pll_system_clock_tree;
   logic clk = 1'b0;
   logic reset = 1'b0;
   logic ref_osc_input;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [6:0] pll_a_clock_ticks;
   logic [6:0] pll_b_clock_ticks;
   logic pll_a_locked;
   logic pll_b_locked;
   logic [31:0] rd;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   osc_ref_model osc (.clk(clk), .reset(reset), .period(8'h08), .pulse(ref_osc_input));
   pll_system_clock_tree dut (.clk(clk), .reset(reset), .ref_osc_input(ref_osc_input),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pll_a_clock_ticks(pll_a_clock_ticks),
      .pll_b_clock_ticks(pll_b_clock_ticks), .pll_a_locked(pll_a_locked),
      .pll_b_locked(pll_b_locked));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Holds the request until waitrequest is seen low, then releases
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Waitrequest and readdata are taken at the same rising edge
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   function automatic logic tk(input logic bank, input int idx);
      return bank ? pll_b_clock_ticks[idx] : pll_a_clock_ticks[idx];
   endfunction
   // Early intervals are skipped while dividers settle after a change
   task automatic span(input logic bank, input int idx, input int exp);
      int n;
      for (int k = 0; k < 4; k++) begin
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (tk(bank, idx) !== 1'b1 && n < 4000);
      end
      check(32'(n), 32'(exp));
   endtask
   task automatic t_reset;
      logic [31:0] ea [10] = '{32'h0, 32'h17, 32'h1, 32'h8000, 32'h8001, 32'h8002, 32'h8003,
                               32'h8000, 32'h8000, 32'h8005};
      logic [31:0] eb [10] = '{32'h0, 32'h17, 32'h1, 32'h8000, 32'h8001, 32'h8002, 32'h8000,
                               32'h8000, 32'h8000, 32'h8000};
      for (int i = 0; i < 20; i++) begin
         bus(1'b0, 8'((i / 10) * 64 + (i % 10) * 4 + ((i % 10) > 2 ? 4 : 0)), 32'h0);
         check(rd, i < 10 ? ea[i] : eb[i - 10]);
      end
   endtask
   task automatic t_refused;
      bus(1'b1, 8'h80, 32'h3);
      bus(1'b0, 8'h80, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 8'h14, 32'h8000);
      bus(1'b0, 8'h14, 32'h0);
      check(rd, 32'h8001);
      bus(1'b1, 8'h40, 32'h3);
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h1);
      bus(1'b1, 8'h40, 32'h0);
   endtask
   task automatic t_modes;
      int ia [7] = '{5, 1, 3, 2, 6, 1, 2};
      int ea [7] = '{16, 32, 64, 48, 96, 64, 48};
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, 8'h48, 32'(p));
         span(1'b1, 0, 8 * (p + 1));
      end
      bus(1'b1, 8'h48, 32'h0);
      bus(1'b1, 8'h50, 32'h8002);
      bus(1'b1, 8'h58, 32'h8004);
      span(1'b1, 0, 24);
      span(1'b1, 2, 40);
      span(1'b1, 1, 16);
      bus(1'b1, 8'h00, 32'h2);
      span(1'b0, 0, 80);
      bus(1'b1, 8'h00, 32'h0);
      for (int i = 0; i < 7; i++) begin
         if (i == 5) bus(1'b1, 8'h24, 32'h8001);
         span(1'b0, ia[i], ea[i]);
      end
   endtask
   task automatic t_active;
      int n;
      bus(1'b1, 8'h50, 32'h8000); // Divider output kept within the device maximum
      // Lowest multiplier that reaches the wanted rate
      bus(1'b1, 8'h44, 32'h3);
      bus(1'b1, 8'h40, 32'h1);
      n = 0;
      while (pll_b_locked !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      bus(1'b0, 8'h4C, 32'h0);
      check(rd & 32'h8000FFFF, 32'h80000008);
      span(1'b1, 0, 2);
      bus(1'b1, 8'h48, 32'h1);
      span(1'b1, 0, 4);
      bus(1'b1, 8'h40, 32'h0);
      span(1'b1, 0, 16);
      // First PLL in active mode must lock on its own reference
      bus(1'b1, 8'h00, 32'h1);
      repeat (40) @(negedge clk);
      check(32'(pll_a_locked), 32'h1);
      bus(1'b1, 8'h00, 32'h0);
      repeat (4) @(negedge clk);
      check(32'(pll_a_locked), 32'h0);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      reset = 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_refused();
      t_modes();
      t_active();
      conclude();
   end
endmodule
